// ==== sleep_sub_cfg.svh ====
/*
 * constants of the power-down and subtract executor: register offsets,
 * field positions, reset values, opcode patterns and phase counts.
 * assumes it is included by its bare name from inside a module body.
 */
`ifndef SLEEP_SUB_CFG_SVH
`define SLEEP_SUB_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the apb port
// ----------------------------------------------------------------------------
`define OFS_ACC        12'h000
`define OFS_STATUS     12'h004
`define OFS_CONTROL    12'h008
`define OFS_STATE      12'h00c

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ST_CARRY       0
`define ST_NIBBLE      1
`define ST_ZERO        2
`define ST_PD          3
`define ST_TO          4
`define CTL_ENABLE     0
`define STA_HALTED     0
`define STA_BUSY       1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACC_RESET      8'h00
`define STATUS_RESET   5'h18
`define CONTROL_RESET  1'b1

// ----------------------------------------------------------------------------
// opcode patterns
// ----------------------------------------------------------------------------
`define OPC_POWERDOWN  14'h0063
`define OPC_LIT_SUB    5'h1e
`define OPC_FILE_SUB   6'h02

// ----------------------------------------------------------------------------
// timing: phases in one instruction cycle, one pclk each
// ----------------------------------------------------------------------------
`define PHASES_PER_CYCLE 4

`endif

// ==== sleep_sub_pkg.sv ====
/*
 * types shared by the power-down and subtract executor.
 * assumes nothing beyond a systemverilog compiler.
 */
package sleep_sub_pkg;

   // ----------------------------------------------------------------------------
   // sequencer states: idle, the four phases, and the halted state
   // ----------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ph_idle,
      ph_first,
      ph_second,
      ph_third,
      ph_fourth,
      ph_halted
   } phase_e;

   // ----------------------------------------------------------------------------
   // decoded instruction class
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0] {
      op_none,
      op_powerdown,
      op_literal_minus_acc,
      op_file_minus_acc
   } op_kind_e;

endpackage

// ==== sub_flag_unit.sv ====
/*
 * eight-bit subtractor a - b with carry, nibble carry and zero flags.
 * assumes the caller registers the outputs; purely combinational.
 */
`timescale 1ns/1ps

module sub_flag_unit (
   input  wire logic [7:0] minuend,     // value subtracted from
   input  wire logic [7:0] subtrahend,  // value taken away
   output logic      [7:0] difference,  // minuend - subtrahend, mod 256
   output logic            carry,       // 1: no borrow out of bit 7
   output logic            nibble_carry,// 1: no borrow out of bit 3
   output logic            zero         // 1: difference is zero
);

   // ----------------------------------------------------------------------------
   // two's complement subtract as a + ~b + 1
   // ----------------------------------------------------------------------------
   logic [8:0] full_sum;   // nine-bit sum, top bit is the carry
   logic [4:0] low_sum;    // low nibble sum, top bit is the nibble carry

   always_comb begin
      full_sum     = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
      low_sum      = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
      difference   = full_sum[7:0];
      carry        = full_sum[8];
      nibble_carry = low_sum[4];
      zero         = (full_sum[7:0] == 8'h00);
   end

endmodule

// ==== sleep_sub_exec.sv ====
/*
 * executor for the power-down instruction and the two subtract
 * instructions of an 8-bit accumulator core, with an apb register port.
 * assumes a synchronous fetch unit presenting one opcode at a time,
 * a register file answering file reads combinationally, and an outside
 * watchdog that clears on the watchdog_clear strobe.
 */
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps

module sleep_sub_exec (
   input  wire logic                    pclk,          // core clock, 10 mhz
   input  wire logic                    presetn,       // async reset, active low
   input  wire logic                    psel,          // apb select
   input  wire logic                    penable,       // apb access phase
   input  wire logic                    pwrite,        // apb direction, 1 write
   input  wire logic [11:0]             paddr,         // apb byte address
   input  wire logic [31:0]             pwdata,        // apb write data
   output logic      [31:0]             prdata,        // apb read data
   output logic                         pready,        // apb ready
   output logic                         pslverr,       // apb error, unmapped
   input  wire logic                    instr_valid,   // opcode offered
   input  wire logic [13:0]             opcode,        // instruction word
   output logic                         instr_ready,   // sequencer can take one
   output logic      [6:0]              file_addr,     // register file address
   input  wire logic [7:0]              file_rdata,    // register file read data
   output logic      [7:0]              file_wdata,    // register file write data
   output logic                         file_we,       // register file write
   output logic      [7:0]              acc,           // accumulator
   output logic                         carry_flag,    // carry flag
   output logic                         nibble_carry_flag, // digit carry flag
   output logic                         zero_flag,     // zero flag
   output logic                         powerdown_flag,// power-down status
   output logic                         timeout_flag,  // time-out status
   output logic                         watchdog_clear,// clears count and prescaler
   output logic                         osc_enable,    // main oscillator runs
   output logic                         halted,        // in power-down
   output sleep_sub_pkg::phase_e        phase,         // current phase
   input  wire logic                    wake           // leave power-down
);
   import sleep_sub_pkg::*;
   `include "sleep_sub_cfg.svh"

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   phase_e      phase_reg, phase_next;         // sequencer state
   logic [13:0] opcode_reg, opcode_next;       // instruction in flight
   op_kind_e    kind_reg, kind_next;           // decoded class
   logic [7:0]  operand_reg, operand_next;     // literal or file value
   logic [7:0]  result_reg, result_next;       // subtract result
   logic [2:0]  flags_reg, flags_next;         // carry, nibble, zero pending
   logic [7:0]  acc_reg, acc_next;             // accumulator
   logic [4:0]  status_reg, status_next;       // status flags
   logic        control_reg, control_next;     // execute enable
   logic        file_we_reg, file_we_next;     // register file write strobe
   logic [7:0]  file_wdata_reg, file_wdata_next; // register file data
   logic        wdt_clr_reg, wdt_clr_next;     // watchdog clear strobe
   logic [31:0] prdata_reg, prdata_next;       // apb read data
   logic        pslverr_reg, pslverr_next;     // apb error

   // ----------------------------------------------------------------------------
   // subtractor
   // ----------------------------------------------------------------------------
   logic [7:0] sub_diff;       // operand - accumulator
   logic       sub_carry;      // no borrow
   logic       sub_nibble;     // no nibble borrow
   logic       sub_zero;       // zero result

   sub_flag_unit u_sub (
      .minuend      (operand_reg),
      .subtrahend   (acc_reg),
      .difference   (sub_diff),
      .carry        (sub_carry),
      .nibble_carry (sub_nibble),
      .zero         (sub_zero)
   );

   // ----------------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------------
   logic apb_access;   // access phase of any transfer
   logic apb_wr;       // write taken this edge
   logic addr_mapped;  // address hits a register

   always_comb begin
      apb_access  = psel && penable;
      apb_wr      = apb_access && pwrite;
      addr_mapped = (paddr == `OFS_ACC) || (paddr == `OFS_STATUS) ||
                    (paddr == `OFS_CONTROL) || (paddr == `OFS_STATE);
   end

   // ----------------------------------------------------------------------------
   // opcode decode
   // ----------------------------------------------------------------------------
   op_kind_e decoded;   // class of the latched opcode

   always_comb begin
      if (opcode_reg == `OPC_POWERDOWN) begin
         decoded = op_powerdown;
      end else if (opcode_reg[13:9] == `OPC_LIT_SUB) begin
         decoded = op_literal_minus_acc;
      end else if (opcode_reg[13:8] == `OPC_FILE_SUB) begin
         decoded = op_file_minus_acc;
      end else begin
         decoded = op_none;                                // other opcodes pass as no-op
      end
   end

   // ----------------------------------------------------------------------------
   // sequencer and execution next state
   // ----------------------------------------------------------------------------
   always_comb begin
      phase_next      = phase_reg;
      opcode_next     = opcode_reg;
      kind_next       = kind_reg;
      operand_next    = operand_reg;
      result_next     = result_reg;
      flags_next      = flags_reg;
      acc_next        = acc_reg;
      status_next     = status_reg;
      control_next    = control_reg;
      file_we_next    = 1'b0;
      file_wdata_next = file_wdata_reg;
      wdt_clr_next    = 1'b0;
      // software writes first; instruction updates below win on the same edge
      if (apb_wr && (paddr == `OFS_ACC)) begin
         acc_next = pwdata[7:0];
      end
      if (apb_wr && (paddr == `OFS_STATUS)) begin
         status_next = pwdata[4:0];
      end
      if (apb_wr && (paddr == `OFS_CONTROL)) begin
         control_next = pwdata[`CTL_ENABLE];
      end
      case (phase_reg)
         ph_idle: begin
            // take an opcode only while execution is enabled
            if (instr_valid && control_reg) begin
               opcode_next = opcode;
               phase_next  = ph_first;
            end
         end
         ph_first: begin
            // first phase: decode
            kind_next  = decoded;
            phase_next = ph_second;
         end
         ph_second: begin
            // second phase: fetch the operand; power-down does nothing
            if (kind_reg == op_literal_minus_acc) begin
               operand_next = opcode_reg[7:0];
            end else if (kind_reg == op_file_minus_acc) begin
               operand_next = file_rdata;
            end
            phase_next = ph_third;
         end
         ph_third: begin
            // third phase: process; file write strobe set up for the fourth
            result_next = sub_diff;
            flags_next  = {sub_zero, sub_nibble, sub_carry};
            if ((kind_reg == op_file_minus_acc) && opcode_reg[7]) begin
               file_we_next    = 1'b1;
               file_wdata_next = sub_diff;
            end
            phase_next = ph_fourth;
         end
         ph_fourth: begin
            // fourth phase: write back or go to sleep
            phase_next = ph_idle;
            case (kind_reg)
               op_powerdown: begin
                  status_next[`ST_PD] = 1'b0;
                  status_next[`ST_TO] = 1'b1;
                  wdt_clr_next        = 1'b1;
                  phase_next          = ph_halted;
               end
               op_literal_minus_acc: begin
                  acc_next                = result_reg;
                  status_next[`ST_CARRY]  = flags_reg[0];
                  status_next[`ST_NIBBLE] = flags_reg[1];
                  status_next[`ST_ZERO]   = flags_reg[2];
               end
               op_file_minus_acc: begin
                  if (!opcode_reg[7]) begin
                     acc_next = result_reg;
                  end
                  status_next[`ST_CARRY]  = flags_reg[0];
                  status_next[`ST_NIBBLE] = flags_reg[1];
                  status_next[`ST_ZERO]   = flags_reg[2];
               end
               default: begin
                  // no-op for anything else
               end
            endcase
         end
         ph_halted: begin
            // oscillator stopped until the wake-up logic says otherwise
            if (wake) begin
               phase_next = ph_idle;
            end
         end
         default: begin
            phase_next = ph_idle;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // apb read and error next values
   // ----------------------------------------------------------------------------
   always_comb begin
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (psel && !penable) begin
         // answer computed in setup, presented through the access phase
         case (paddr)
            `OFS_ACC:     prdata_next = {24'h00_0000, acc_reg};
            `OFS_STATUS:  prdata_next = {27'h000_0000, status_reg};
            `OFS_CONTROL: prdata_next = {31'h0000_0000, control_reg};
            `OFS_STATE: begin
               prdata_next[`STA_HALTED] = (phase_reg == ph_halted);
               prdata_next[`STA_BUSY]   = (phase_reg != ph_idle) &&
                                          (phase_reg != ph_halted);
            end
            default: prdata_next = 32'h0000_0000;
         endcase
         pslverr_next = !addr_mapped;
      end else if (apb_access) begin
         prdata_next  = prdata_reg;
         pslverr_next = pslverr_reg;
      end
   end

   // ----------------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg      <= ph_idle;
         opcode_reg     <= 14'h0000;
         kind_reg       <= op_none;
         operand_reg    <= 8'h00;
         result_reg     <= 8'h00;
         flags_reg      <= 3'h0;
         acc_reg        <= `ACC_RESET;
         status_reg     <= `STATUS_RESET;
         control_reg    <= `CONTROL_RESET;
         file_we_reg    <= 1'b0;
         file_wdata_reg <= 8'h00;
         wdt_clr_reg    <= 1'b0;
         prdata_reg     <= 32'h0000_0000;
         pslverr_reg    <= 1'b0;
      end else begin
         phase_reg      <= phase_next;
         opcode_reg     <= opcode_next;
         kind_reg       <= kind_next;
         operand_reg    <= operand_next;
         result_reg     <= result_next;
         flags_reg      <= flags_next;
         acc_reg        <= acc_next;
         status_reg     <= status_next;
         control_reg    <= control_next;
         file_we_reg    <= file_we_next;
         file_wdata_reg <= file_wdata_next;
         wdt_clr_reg    <= wdt_clr_next;
         prdata_reg     <= prdata_next;
         pslverr_reg    <= pslverr_next;
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   always_comb begin
      prdata            = prdata_reg;
      pslverr           = pslverr_reg && apb_access;
      pready            = 1'b1;                    // every access ends in one cycle
      instr_ready       = (phase_reg == ph_idle) && control_reg;
      file_addr         = opcode_reg[6:0];
      file_wdata        = file_wdata_reg;
      file_we           = file_we_reg;
      acc               = acc_reg;
      carry_flag        = status_reg[`ST_CARRY];
      nibble_carry_flag = status_reg[`ST_NIBBLE];
      zero_flag         = status_reg[`ST_ZERO];
      powerdown_flag    = status_reg[`ST_PD];
      timeout_flag      = status_reg[`ST_TO];
      watchdog_clear    = wdt_clr_reg;
      halted            = (phase_reg == ph_halted);
      osc_enable        = (phase_reg != ph_halted);
      phase             = phase_reg;
   end

endmodule

// ==== sleep_sub_exec_monitor.sv ====
/*
 * concurrent checks on the ports of the power-down and subtract executor.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps

module sleep_sub_exec_monitor
   import sleep_sub_pkg::*;
(
   input wire logic        pclk,          // core clock
   input wire logic        presetn,       // async reset, active low
   input wire logic        instr_valid,   // opcode offered
   input wire logic [13:0] opcode,        // instruction word
   input wire logic        instr_ready,   // sequencer can take one
   input wire logic [7:0]  file_wdata,    // register file write data
   input wire logic        file_we,       // register file write
   input wire logic [7:0]  acc,           // accumulator
   input wire logic        carry_flag,    // carry flag
   input wire logic        zero_flag,     // zero flag
   input wire logic        powerdown_flag,// power-down status
   input wire logic        timeout_flag,  // time-out status
   input wire logic        watchdog_clear,// watchdog clear strobe
   input wire logic        osc_enable,    // oscillator runs
   input wire logic        halted,        // in power-down
   input wire phase_e      phase,         // current phase
   input wire logic        wake           // leave power-down
);
   `include "sleep_sub_cfg.svh"

   // ----------------------------------------------------------------------------
   // helpers: instruction take and its kinds
   // ----------------------------------------------------------------------------
   wire take = instr_valid && instr_ready; // edge at which an opcode is taken

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_pd_take;
      take && opcode == `OPC_POWERDOWN;
   endsequence
   sequence s_lit_take;
      take && opcode[13:9] == `OPC_LIT_SUB;
   endsequence
   sequence s_filew_take;
      take && opcode[13:8] == `OPC_FILE_SUB && opcode[7];
   endsequence
   sequence s_phases;
      phase == ph_first ##1 phase == ph_second ##1 phase == ph_third ##1 phase == ph_fourth;
   endsequence

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   AST_PD_HALT: assert property (s_pd_take |-> ##6 halted && !osc_enable)
      else $error("power-down did not halt with oscillator stopped");
   AST_PD_FLAGS: assert property (s_pd_take |-> ##6 !powerdown_flag && timeout_flag)
      else $error("power-down status flags wrong");
   AST_WDOG_PULSE: assert property (s_pd_take |-> (!watchdog_clear) [*5] ##1 watchdog_clear ##1 !watchdog_clear)
      else $error("watchdog clear pulse misplaced");
   AST_PD_PHASES: assert property (s_pd_take |-> ##1 s_phases ##1 phase == ph_halted)
      else $error("power-down phase order wrong");
   AST_LIT_RESULT: assert property (s_lit_take |-> ##5 acc == 8'($past(opcode, 5)) - $past(acc, 5)
      && carry_flag == (8'($past(opcode, 5)) >= $past(acc, 5)))
      else $error("literal subtract result or carry wrong");
   AST_FILE_WRITE: assert property (s_filew_take |-> ##4 file_we ##1 !file_we)
      else $error("file write pulse missing");
   AST_FILE_TO_ACC: assert property (take && opcode[13:7] == 7'h04 |-> ##1 (!file_we) [*6])
      else $error("file written with destination bit clear");
   AST_FILE_ZERO: assert property (s_filew_take |-> ##6 zero_flag == ($past(file_wdata) == 8'h00))
      else $error("zero flag disagrees with file result");
   AST_BUSY_REFUSE: assert property (phase != ph_idle |-> !instr_ready)
      else $error("opcode accepted while busy");
   AST_WAKE: assert property (halted && wake |=> !halted && osc_enable)
      else $error("wake did not leave power-down");
endmodule

bind sleep_sub_exec sleep_sub_exec_monitor i_sleep_sub_exec_monitor (
   .pclk(pclk), .presetn(presetn), .instr_valid(instr_valid), .opcode(opcode),
   .instr_ready(instr_ready), .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
   .carry_flag(carry_flag), .zero_flag(zero_flag), .powerdown_flag(powerdown_flag),
   .timeout_flag(timeout_flag), .watchdog_clear(watchdog_clear),
   .osc_enable(osc_enable), .halted(halted), .phase(phase), .wake(wake));

// ==== test_sleep_sub_exec.sv ====
/*
 * self-checking bench for the power-down and subtract executor.
 * assumes the package, the cfg header and the bound monitor are compiled.
 */
`timescale 1ns/1ps

module test_sleep_sub_exec;
   import sleep_sub_pkg::*;
   `include "sleep_sub_cfg.svh"

   // ----------------------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------------------
   logic        pclk = 1'b0;       // 100 ns clock
   logic        presetn = 1'b0;    // reset, active low
   logic        psel = 1'b0;       // apb select
   logic        penable = 1'b0;    // apb access
   logic        pwrite = 1'b0;     // apb direction
   logic [11:0] paddr = 12'h000;   // apb address
   logic [31:0] pwdata = 32'h0;    // apb write data
   logic        instr_valid = 1'b0;// opcode offered
   logic [13:0] opcode = 14'h0000; // instruction word
   logic [7:0]  file_rdata = 8'h00;// register file data
   logic        wake = 1'b0;       // wake request
   logic [31:0] prdata;            // apb read data
   logic        pready, pslverr, instr_ready, file_we, carry_flag, nibble_carry_flag;
   logic        zero_flag, powerdown_flag, timeout_flag, watchdog_clear, osc_enable, halted;
   logic [6:0]  file_addr;         // register file address
   logic [7:0]  file_wdata, acc;   // file write data, accumulator
   phase_e      phase;             // sequencer phase
   int          checks = 0;        // comparisons made
   int          miscompares = 0;   // comparisons failed

   always #50 pclk = ~pclk;

   sleep_sub_exec i_sleep_sub_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .opcode(opcode),
      .instr_ready(instr_ready), .file_addr(file_addr), .file_rdata(file_rdata),
      .file_wdata(file_wdata), .file_we(file_we), .acc(acc), .carry_flag(carry_flag),
      .nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
      .powerdown_flag(powerdown_flag), .timeout_flag(timeout_flag),
      .watchdog_clear(watchdog_clear), .osc_enable(osc_enable), .halted(halted),
      .phase(phase), .wake(wake));

   // ----------------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // compare one value, four-state exact
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   // one apb transfer, waits for pready under a bound
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         complete_run();
      end
   endtask

   // offer an opcode, return 1 ns after the edge that opens the fourth phase
   task automatic exec(input logic [13:0] op);
      int n;
      @(posedge pclk);
      instr_valid <= 1'b1;
      opcode <= op;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (instr_ready !== 1'b1 && n < 20);
      instr_valid <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         complete_run();
      end
      repeat (3) @(posedge pclk);
      #1;
   endtask

   // ----------------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      logic e;
      apb(1'b0, `OFS_STATUS, 32'h0, d, e);
      chk("status reset", 32'h18, d);
      apb(1'b1, `OFS_ACC, 32'h5a, d, e);
      apb(1'b0, `OFS_ACC, 32'h0, d, e);
      chk("acc read", 32'h5a, d);
      apb(1'b0, 12'h010, 32'h0, d, e);
      chk("unmapped err", 32'h1, 32'(e));
      apb(1'b1, `OFS_CONTROL, 32'h0, d, e);
      #1;
      chk("ready disabled", 32'h0, 32'(instr_ready));
      apb(1'b1, `OFS_CONTROL, 32'h1, d, e);
   endtask

   task automatic t_lit();
      logic [7:0] ks[4] = '{8'h02, 8'h02, 8'h02, 8'h10};
      logic [7:0] ws[4] = '{8'h01, 8'h02, 8'h03, 8'h01};
      logic [7:0] r;
      logic [31:0] d;
      logic e;
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, `OFS_ACC, 32'(ws[i]), d, e);
         exec({`OPC_LIT_SUB, i[0], ks[i]});
         @(posedge pclk);
         #1;
         r = ks[i] - ws[i];
         chk("lit acc", 32'(r), 32'(acc));
         chk("lit flags", {29'h0, r == 8'h00, ks[i][3:0] >= ws[i][3:0], ks[i] >= ws[i]},
             {29'h0, zero_flag, nibble_carry_flag, carry_flag});
      end
   endtask

   task automatic t_file();
      logic [31:0] d;
      logic e;
      apb(1'b1, `OFS_ACC, 32'h02, d, e);
      file_rdata <= 8'h03;
      exec({`OPC_FILE_SUB, 1'b1, 7'h15});
      chk("file we d1", {8'h01, 1'b1, 7'h15}, {file_wdata, file_we, file_addr});
      @(posedge pclk);
      #1;
      chk("file d1 acc flags", {8'h02, 3'b001}, {acc, zero_flag, 2'(carry_flag)});
      @(posedge pclk);
      file_rdata <= 8'h01;
      exec({`OPC_FILE_SUB, 1'b0, 7'h0a});
      chk("file we d0", 32'h0, 32'(file_we));
      @(posedge pclk);
      #1;
      chk("file d0 acc flags", {8'hff, 3'b000}, {acc, zero_flag, 2'(carry_flag)});
   endtask

   task automatic t_pd();
      logic [31:0] d;
      logic e;
      apb(1'b1, `OFS_STATUS, 32'h08, d, e);
      exec(14'h0062);
      @(posedge pclk);
      #1;
      chk("near opcode", 32'h1, {halted, timeout_flag, powerdown_flag});
      exec(`OPC_POWERDOWN);
      chk("pd fourth", 32'h1, {halted, watchdog_clear, osc_enable});
      @(posedge pclk);
      #1;
      chk("pd halt", {4'b1001, 3'(ph_halted)},
          {halted, osc_enable, powerdown_flag, timeout_flag, phase});
      chk("wdog pulse", 32'h1, 32'(watchdog_clear));
      @(posedge pclk);
      #1;
      chk("wdog end", 32'h2, {halted, watchdog_clear});
      apb(1'b0, `OFS_STATE, 32'h0, d, e);
      chk("state halted", 32'h1, d);
      wake <= 1'b1;
      @(posedge pclk);
      wake <= 1'b0;
      #1;
      chk("wake", 32'h3, {instr_ready, osc_enable});
   endtask

   // ----------------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_lit();
      t_file();
      t_pd();
      complete_run();
   end
endmodule
